// >>> hw/sebfe_pkg.sv
package sebfe_pkg;

    // Bit slots within one nine-clock byte frame, counted in falling serial clock edges.
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_STEP = 4'h1;

    localparam int BYTE_MSB = 7;
    localparam int BYTE_NEXT = 6;

    // Target address byte layout.
    localparam int DIR_POS = 0;
    localparam int MSB_POS = 1;
    localparam int CS_POS = 2;
    localparam int UPPER_POS = 3;
    localparam int TYPE_LSB = 4;
    localparam int TYPE_MSB = 7;

    // Array address and protect latch layout.
    localparam int ADDR_W = 17;
    localparam int ADDR_MSB = 16;
    localparam int PROT_ADDR_LSB = 10;
    localparam int PROT_TB_POS = 0;
    localparam int PROT_RANGE_LSB = 1;
    localparam int PROT_RANGE_MSB = 7;

    // Arbitrary value; the real type code is set per instance.
    localparam logic [3:0] TYPE_CODE_DEF = 4'h5;
    localparam logic [7:0] PROT_LATCH_DEF = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [16:0] ADDR_ZERO = 17'h0_0000;

    // Event toggles passed from the link side to the system clock side.
    localparam int TG_START = 0;
    localparam int TG_STOP = 1;
    localparam int TG_WRITE = 2;
    localparam int TG_READ = 3;
    localparam int TG_ADDR = 4;
    localparam int TG_W = 5;

    localparam int ST_SEL = 0;
    localparam int ST_BLK = 1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_ADRH = 3'b010,
        ST_ADRL = 3'b011,
        ST_WDATA = 3'b100,
        ST_RDATA = 3'b101,
        ST_IGNORE = 3'b110
    } sebfe_state_t;

endpackage

// >>> hw/sebfe_top.sv
`timescale 1ns/1ps
`default_nettype none
module sebfe_top
    import sebfe_pkg::*;
#(
    parameter logic [7:0] PROTECT_LATCH = PROT_LATCH_DEF,
    parameter logic [3:0] TYPE_CODE = TYPE_CODE_DEF
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic serialClk,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe,
    input wire logic writeProtectIn,
    input wire logic chipSelectPin,
    input wire logic [7:0] readData,
    output logic [16:0] arrayAddr,
    output logic addrStrobe,
    output logic [7:0] writeData,
    output logic writeStrobe,
    output logic readStrobe,
    output logic standby,
    output logic selected,
    output logic writeBlocked
);

    function automatic logic protBlocked(input logic wp, input logic [7:0] latch, input logic [6:0] addrTop);
        logic below;
        below = addrTop < latch[PROT_RANGE_MSB:PROT_RANGE_LSB];
        if (!wp) begin
            protBlocked = 1'b0;
        end else if (latch[PROT_TB_POS]) begin
            protBlocked = !below;
        end else begin
            protBlocked = below;
        end
    endfunction

    // Start and stop seen directly on the data line, clocked by its own edges.
    logic startTgl_r;
    logic stopTgl_r;

    // Link side, clocked by the serial clock.
    logic sdaPos_r;
    logic startSeen_r;
    logic stopSeen_r;
    logic [1:0] wpSync_r;
    logic [1:0] csSync_r;
    logic [7:0] rdS1_r;
    logic [7:0] rdS2_r;
    sebfe_state_t state_r;
    sebfe_state_t state_nxt;
    logic [3:0] bitCnt_r;
    logic [3:0] bitCnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [7:0] tx_nxt;
    logic msb_r;
    logic [7:0] hi_r;
    logic [7:0] lo_r;
    logic [7:0] wrData_r;
    logic oe_r;
    logic oe_nxt;
    logic wrTgl_r;
    logic rdTgl_r;
    logic addrTgl_r;
    logic selected_r;
    logic blocked_r;

    // System side.
    logic [TG_W-1:0] tglS1_r;
    logic [TG_W-1:0] tglS2_r;
    logic [TG_W-1:0] tglS3_r;
    logic [1:0] statS1_r;
    logic [1:0] statS2_r;
    logic standby_r;
    logic writeStrobe_r;
    logic readStrobe_r;
    logic addrStrobe_r;
    logic [16:0] arrayAddr_r;
    logic [7:0] writeData_r;
    logic sdaLow_r;

    // A falling data line while the clock is high marks a start; a rising one marks a stop.
    always_ff @(negedge serialDataIn or posedge sys_rst) begin
        if (sys_rst) begin
            startTgl_r <= 1'b0;
        end else if (serialClk) begin
            startTgl_r <= ~startTgl_r;
        end
    end

    always_ff @(posedge serialDataIn or posedge sys_rst) begin
        if (sys_rst) begin
            stopTgl_r <= 1'b0;
        end else if (serialClk) begin
            stopTgl_r <= ~stopTgl_r;
        end
    end

    // Data bits are sampled on the rising clock edge only.
    always_ff @(posedge serialClk or posedge sys_rst) begin
        if (sys_rst) begin
            sdaPos_r <= 1'b1;
        end else begin
            sdaPos_r <= serialDataIn;
        end
    end

    logic startPend;
    logic stopPend;
    logic frameCut;
    logic [7:0] byteIn;
    logic lastBit;
    logic ackEnd;
    logic devMatch;
    logic [16:0] addrFull;
    logic blockNow;
    logic capDev;
    logic capHi;
    logic capLo;
    logic capData;
    logic ackGive;
    logic masterAck;
    logic txLoad;
    logic txShift;

    // A start or stop toggle is set while the clock is high, well ahead of the next falling edge.
    assign startPend = startTgl_r ^ startSeen_r;
    assign stopPend = stopTgl_r ^ stopSeen_r;
    assign frameCut = startPend | stopPend;
    assign byteIn = {shift_r[BYTE_NEXT:0], sdaPos_r};
    assign lastBit = (bitCnt_r == BIT_LAST) & ~frameCut;
    assign ackEnd = bitCnt_r == ACK_SLOT;
    assign devMatch = (byteIn[TYPE_MSB:TYPE_LSB] == TYPE_CODE)
        & ~byteIn[UPPER_POS]
        & (byteIn[CS_POS] == csSync_r[1]);
    assign addrFull = {msb_r, hi_r, lo_r};
    assign blockNow = protBlocked(wpSync_r[1], PROTECT_LATCH, addrFull[ADDR_MSB:PROT_ADDR_LSB]);
    assign capDev = (state_r == ST_DEV) & lastBit & devMatch;
    assign capHi = (state_r == ST_ADRH) & lastBit;
    assign capLo = (state_r == ST_ADRL) & lastBit;
    assign capData = (state_r == ST_WDATA) & lastBit & ~blockNow;
    assign ackGive = capDev | capHi | capLo | capData;
    assign masterAck = ~sdaPos_r;
    assign txLoad = (state_r == ST_RDATA) & ackEnd & masterAck & ~frameCut;
    assign txShift = (state_r == ST_RDATA) & (bitCnt_r < BIT_LAST);

    // The line is only ever pulled low; a released line is left to the pull-up.
    assign oe_nxt = frameCut ? 1'b0
        : txLoad ? ~rdS2_r[BYTE_MSB]
        : txShift ? ~tx_r[BYTE_NEXT]
        : lastBit ? ackGive
        : 1'b0;
    assign tx_nxt = txLoad ? rdS2_r : txShift ? {tx_r[BYTE_NEXT:0], 1'b0} : tx_r;
    assign bitCnt_nxt = (startPend | ackEnd) ? CNT_ZERO : bitCnt_r + CNT_STEP;

    always_comb begin
        state_nxt = state_r;
        if (startPend) begin
            state_nxt = ST_DEV;
        end else if (stopPend) begin
            state_nxt = ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_IDLE;
                end
                ST_DEV: begin
                    if (lastBit) begin
                        if (!devMatch) begin
                            state_nxt = ST_IGNORE;
                        end else if (byteIn[DIR_POS]) begin
                            state_nxt = ST_RDATA;
                        end else begin
                            state_nxt = ST_ADRH;
                        end
                    end
                end
                ST_ADRH: begin
                    if (lastBit) begin
                        state_nxt = ST_ADRL;
                    end
                end
                ST_ADRL: begin
                    if (lastBit) begin
                        state_nxt = ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (lastBit && blockNow) begin
                        state_nxt = ST_IGNORE;
                    end
                end
                ST_RDATA: begin
                    if (ackEnd && !masterAck) begin
                        state_nxt = ST_IGNORE;
                    end
                end
                ST_IGNORE: begin
                    state_nxt = ST_IGNORE;
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // Slow pins are synchronised on the link clock before the frame logic reads them.
    always_ff @(negedge serialClk or posedge sys_rst) begin
        if (sys_rst) begin
            wpSync_r <= 2'h0;
            csSync_r <= 2'h0;
            rdS1_r <= BYTE_ZERO;
            rdS2_r <= BYTE_ZERO;
        end else begin
            wpSync_r <= {wpSync_r[0], writeProtectIn};
            csSync_r <= {csSync_r[0], chipSelectPin};
            rdS1_r <= readData;
            rdS2_r <= rdS1_r;
        end
    end

    always_ff @(negedge serialClk or posedge sys_rst) begin
        if (sys_rst) begin
            startSeen_r <= 1'b0;
            stopSeen_r <= 1'b0;
            state_r <= ST_IDLE;
            bitCnt_r <= CNT_ZERO;
            shift_r <= BYTE_ZERO;
            tx_r <= BYTE_ZERO;
            oe_r <= 1'b0;
        end else begin
            startSeen_r <= startTgl_r;
            stopSeen_r <= stopTgl_r;
            state_r <= state_nxt;
            bitCnt_r <= bitCnt_nxt;
            shift_r <= byteIn;
            tx_r <= tx_nxt;
            oe_r <= oe_nxt;
        end
    end

    // The protect latch is a parameter, so no bus sequence can reach it.
    always_ff @(negedge serialClk or posedge sys_rst) begin
        if (sys_rst) begin
            msb_r <= 1'b0;
            hi_r <= BYTE_ZERO;
            lo_r <= BYTE_ZERO;
            wrData_r <= BYTE_ZERO;
        end else begin
            if (capDev) begin
                msb_r <= byteIn[MSB_POS];
            end
            if (capHi) begin
                hi_r <= byteIn;
            end
            if (capLo) begin
                lo_r <= byteIn;
            end
            if (capData) begin
                wrData_r <= byteIn;
            end
        end
    end

    always_ff @(negedge serialClk or posedge sys_rst) begin
        if (sys_rst) begin
            wrTgl_r <= 1'b0;
            rdTgl_r <= 1'b0;
            addrTgl_r <= 1'b0;
            selected_r <= 1'b0;
            blocked_r <= 1'b0;
        end else begin
            wrTgl_r <= wrTgl_r ^ capData;
            rdTgl_r <= rdTgl_r ^ txLoad;
            addrTgl_r <= addrTgl_r ^ capLo;
            selected_r <= (frameCut || state_nxt == ST_IGNORE) ? 1'b0 : (capDev ? 1'b1 : selected_r);
            blocked_r <= startPend ? 1'b0 : (((state_r == ST_WDATA) & lastBit & blockNow) | blocked_r);
        end
    end

    // Toggles cross to the system clock through two flops; a third gives the edge.
    logic [TG_W-1:0] tglNow;
    logic [TG_W-1:0] tglPulse;
    logic standby_nxt;

    assign tglNow = {addrTgl_r, rdTgl_r, wrTgl_r, stopTgl_r, startTgl_r};
    assign tglPulse = tglS2_r ^ tglS3_r;
    assign standby_nxt = tglPulse[TG_STOP] ? 1'b1 : (tglPulse[TG_START] ? 1'b0 : standby_r);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tglS1_r <= '0;
            tglS2_r <= '0;
            tglS3_r <= '0;
            statS1_r <= 2'h0;
            statS2_r <= 2'h0;
        end else begin
            tglS1_r <= tglNow;
            tglS2_r <= tglS1_r;
            tglS3_r <= tglS2_r;
            statS1_r <= {blocked_r, selected_r};
            statS2_r <= statS1_r;
        end
    end

    // Address and data are held on the link side for many serial clocks after each toggle.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            standby_r <= 1'b1;
            writeStrobe_r <= 1'b0;
            readStrobe_r <= 1'b0;
            addrStrobe_r <= 1'b0;
            arrayAddr_r <= ADDR_ZERO;
            writeData_r <= BYTE_ZERO;
            sdaLow_r <= 1'b0;
        end else begin
            standby_r <= standby_nxt;
            writeStrobe_r <= tglPulse[TG_WRITE];
            readStrobe_r <= tglPulse[TG_READ];
            addrStrobe_r <= tglPulse[TG_ADDR];
            sdaLow_r <= 1'b0;
            if (tglPulse[TG_ADDR]) begin
                arrayAddr_r <= addrFull;
            end
            if (tglPulse[TG_WRITE]) begin
                writeData_r <= wrData_r;
            end
        end
    end

    assign serialDataOut = sdaLow_r;
    assign serialDataOe = oe_r;
    assign arrayAddr = arrayAddr_r;
    assign addrStrobe = addrStrobe_r;
    assign writeData = writeData_r;
    assign writeStrobe = writeStrobe_r;
    assign readStrobe = readStrobe_r;
    assign standby = standby_r;
    assign selected = statS2_r[ST_SEL];
    assign writeBlocked = statS2_r[ST_BLK];

endmodule // sebfe_top
`default_nettype wire

// >>> tb/sebfe_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sebfe_top_asserts
    import sebfe_pkg::*;
#(
    parameter logic [7:0] PROTECT_LATCH = PROT_LATCH_DEF
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    input wire logic writeProtectIn,
    input wire logic [16:0] arrayAddr,
    input wire logic addrStrobe,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    input wire logic standby,
    input wire logic writeBlocked
);
    wire logic [6:0] upperAddr = arrayAddr[ADDR_MSB:PROT_ADDR_LSB];
    wire logic [6:0] bound = PROTECT_LATCH[PROT_RANGE_MSB:PROT_RANGE_LSB];
    wire logic inRange = PROTECT_LATCH[PROT_TB_POS] ? (upperAddr >= bound) : (upperAddr < bound);
    wire logic guarded = writeProtectIn && inRange;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_sda_never_high: assert property (serialDataOut == 1'b0)
        else $error("SDA output value is not low");
    a_idle_released: assert property (standby |-> !serialDataOe)
        else $error("SDA pulled low while in standby");
    a_addr_pulse: assert property (addrStrobe |=> !addrStrobe [*8])
        else $error("address strobe too long or too close");
    a_write_pulse: assert property (writeStrobe |=> !writeStrobe [*8])
        else $error("write strobe too long or too close");
    a_read_pulse: assert property (readStrobe |=> !readStrobe [*8])
        else $error("read strobe too long or too close");
    a_write_guard: assert property (writeStrobe |-> !guarded)
        else $error("write accepted inside protected range");
    a_block_cause: assert property ($rose(writeBlocked) |-> guarded)
        else $error("write refused outside protected range");
    a_blocked_quiet: assert property (writeBlocked |-> !writeStrobe)
        else $error("write strobe after a refused byte");
    a_addr_change: assert property ($changed(arrayAddr) |-> addrStrobe)
        else $error("address changed without strobe");

    cover property (writeStrobe);
    cover property ($rose(writeBlocked));
    cover property (readStrobe ##[1:300] readStrobe);
endmodule // sebfe_top_asserts

bind sebfe_top sebfe_top_asserts #(.PROTECT_LATCH(PROTECT_LATCH)) u_chk (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe),
    .writeProtectIn(writeProtectIn),
    .arrayAddr(arrayAddr),
    .addrStrobe(addrStrobe),
    .writeStrobe(writeStrobe),
    .readStrobe(readStrobe),
    .standby(standby),
    .writeBlocked(writeBlocked)
);
`default_nettype wire

// >>> tb/sebfe_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sebfe_ctrl_model (
    output logic scl,
    output logic sdaLow,
    input wire logic sda
);
    localparam realtime Q = 3.75;

    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    // Data moves a quarter period after the clock falls and is held through the rising edge.
    task automatic bitOut(input logic b, output logic s);
        #Q sdaLow = !b;
        #Q scl = 1'b1;
        s = sda;
        #(2 * Q) scl = 1'b0;
    endtask

    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitOut(d[i], s);
        end
        bitOut(1'b1, s);
        ack = !s;
    endtask

    task automatic readByte(input logic ackIt, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitOut(1'b1, s);
            d[i] = s;
        end
        bitOut(!ackIt, s);
    endtask

    task automatic start;
        #Q sdaLow = 1'b0;
        #Q scl = 1'b1;
        #Q sdaLow = 1'b1;
        #Q scl = 1'b0;
    endtask

    task automatic stop;
        #Q sdaLow = 1'b1;
        #Q scl = 1'b1;
        #Q sdaLow = 1'b0;
        #(4 * Q);
    endtask
endmodule // sebfe_ctrl_model
`default_nettype wire

// >>> tb/sebfe_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sebfe_bench
    import sebfe_pkg::*;
;
    localparam logic [7:0] LATCH = 8'h81;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic writeProtectIn = 1'b0;
    logic chipSelectPin = 1'b0;
    logic [7:0] readData = 8'h00;
    wire logic scl;
    wire logic ctrlLow;
    wire logic sda;
    logic sdaOut, sdaOe, addrStrobe, writeStrobe, readStrobe, standby, selected, writeBlocked, k;
    logic [16:0] arrayAddr, a;
    logic [7:0] writeData, bad;
    logic [31:0] seed = 32'h0000_0c71;
    logic [31:0] rdSeed = 32'h0000_0c71;
    logic [31:0] expQ[$];
    logic [7:0] rdQ[$];
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    always #2.5 sys_clk = ~sys_clk;
    // Open-drain wire with pull-up: low when either party pulls.
    assign sda = !(ctrlLow || (sdaOe && !sdaOut));

    sebfe_ctrl_model CTRL (.scl(scl), .sdaLow(ctrlLow), .sda(sda));
    sebfe_top #(.PROTECT_LATCH(LATCH), .TYPE_CODE(TYPE_CODE_DEF)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .serialClk(scl), .serialDataIn(sda),
        .serialDataOut(sdaOut), .serialDataOe(sdaOe), .writeProtectIn(writeProtectIn),
        .chipSelectPin(chipSelectPin), .readData(readData), .arrayAddr(arrayAddr),
        .addrStrobe(addrStrobe), .writeData(writeData), .writeStrobe(writeStrobe),
        .readStrobe(readStrobe), .standby(standby), .selected(selected), .writeBlocked(writeBlocked));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [7:0] dev(input logic m, input logic r);
        return {TYPE_CODE_DEF, 1'b0, chipSelectPin, m, r};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic pins(input logic w, input logic c);
        @(negedge sys_clk);
        writeProtectIn = w;
        chipSelectPin = c;
    endtask

    task automatic head(input logic [16:0] ad, input logic r);
        CTRL.start();
        CTRL.sendByte(dev(ad[16], r), k);
        check(32'(k), 32'h1);
    endtask

    task automatic addrPhase(input logic [16:0] ad);
        head(ad, 1'b0);
        CTRL.sendByte(ad[15:8], k);
        check(32'(k), 32'h1);
        expQ.push_back({4'h1, 11'h0, ad});
        CTRL.sendByte(ad[7:0], k);
        check(32'(k), 32'h1);
    endtask

    task automatic wr(input logic [16:0] ad, input logic [7:0] d, input logic ok);
        addrPhase(ad);
        if (ok) expQ.push_back({4'h2, 20'h0, d});
        CTRL.sendByte(d, k);
        check(32'(k), 32'(ok));
        repeat (6) @(negedge sys_clk);
        check({29'h0, writeBlocked, standby, selected}, {29'h0, !ok, 1'b0, ok});
        CTRL.stop();
        repeat (6) @(negedge sys_clk);
        check(32'(standby), 32'h1);
    endtask

    // The monitor takes the oldest note whenever the address or write strobe shows a result.
    always @(negedge sys_clk) begin
        cycles++;
        if (addrStrobe === 1'b1 || writeStrobe === 1'b1) begin
            check(addrStrobe ? {4'h1, 11'h0, arrayAddr} : {4'h2, 20'h0, writeData},
                (expQ.size() > 0) ? expQ.pop_front() : 32'hDEAD_BEEF);
        end
        if (cycles == 8000) begin
            err_total++;
            results();
        end
    end

    // A fresh byte is presented once the previous one has been loaded.
    always @(negedge sys_clk) begin
        if (readStrobe === 1'b1) begin
            rdSeed = xs(rdSeed);
            readData <= rdSeed[7:0];
            rdQ.push_back(rdSeed[7:0]);
        end
    end

    initial begin
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(negedge sys_clk);
        CTRL.bitOut(1'b1, k);
        CTRL.sendByte(dev(1'b0, 1'b0), k);
        check(32'(k), 32'h0);
        CTRL.stop();
        $display("test no_start done");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            pins(i[1], seed[31]);
            a = i[0] ? {7'h40, seed[9:0]} : {7'h3F, seed[9:0]};
            wr(a, seed[17:10], !(i[1] && i[0]));
        end
        $display("test protect done");
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            addrPhase(seed[16:0]);
            rdQ.delete();
            rdQ.push_back(readData);
            head(seed[16:0], 1'b1);
            CTRL.readByte(1'b1, bad);
            check(32'(bad), 32'(rdQ.pop_front()));
            CTRL.readByte(1'b0, bad);
            check(32'(bad), 32'(rdQ.pop_front()));
            CTRL.stop();
        end
        $display("test read done");
        for (int j = 0; j < 2; j++) begin
            pins(1'b0, j[0]);
            for (int i = 0; i < 3; i++) begin
                bad = dev(1'b0, 1'b0) ^ ((i == 0) ? 8'h80 : (i == 1) ? 8'h08 : 8'h04);
                CTRL.start();
                CTRL.sendByte(bad, k);
                check(32'(k), 32'h0);
                CTRL.sendByte(8'h00, k);
                check({30'h0, k, selected}, 32'h0);
                CTRL.stop();
            end
        end
        $display("test select done");
        repeat (10) @(negedge sys_clk);
        check(32'(expQ.size()), 32'h0);
        results();
    end
endmodule // sebfe_bench
`default_nettype wire
